// ==== core_timing_map.svh ====
`ifndef CORE_TIMING_MAP_SVH
`define CORE_TIMING_MAP_SVH

// Widths
`define PC_W 16
`define CYC_W 4
`define LEN_W 2
`define BP_NUM 4
`define BP_IDX_W 2

// Instruction lengths in program bytes
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3

// Timing counts in system clocks
`define CYC_FIRST 4'h1
`define CYC_XFER 4'h3
`define CYC_MULTIPLY 4'h4
`define CYC_RET 4'h5
`define CYC_MAX 4'h8
`define BR_PENALTY 4'h1

// Reset values
`define PC_RESET 16'h0000
`define OPCODE_RESET 8'h00

// Opcodes the sequencer checks by value
`define OP_MULTIPLY 8'hA4
`define OP_DIV 8'h84

`endif

// ==== core_timing_pkg.sv ====
package core_timing_pkg;

    // Operand form: bytes, not-taken clocks, and whether it branches
    typedef enum logic [3:0] {
        FORM_1_1, FORM_1_2, FORM_1_3, FORM_1_4, FORM_1_5, FORM_1_8,
        FORM_2_2, FORM_2_3, FORM_3_3, FORM_3_4, FORM_B22, FORM_B33, FORM_B34
    } form_t;

    // Sequencer run state
    typedef enum logic {ST_RUN, ST_HALT} state_t;

endpackage

// ==== dec_if.sv ====
`timescale 1ns/1ns
`include "core_timing_map.svh"
interface dec_if;
    logic [7:0] opcode;
    logic [`LEN_W-1:0] len;
    logic [`CYC_W-1:0] cyc_nt;
    logic [`CYC_W-1:0] cyc_tk;
    logic branch;
    logic xdata;
    logic xdata_wr;
    logic code_move;

    modport dec (
        input opcode,
        output len, cyc_nt, cyc_tk, branch, xdata, xdata_wr, code_move
    );
    modport user (
        output opcode,
        input len, cyc_nt, cyc_tk, branch, xdata, xdata_wr, code_move
    );
endinterface

// ==== opcode_timing_decode.sv ====
`timescale 1ns/1ns
`include "core_timing_map.svh"
module opcode_timing_decode (
    dec_if.dec d
);
    import core_timing_pkg::*;

    logic [3:0] hi;
    logic [3:0] lo;
    form_t form;

    assign hi = d.opcode[7:4];
    assign lo = d.opcode[3:0];

    // Opcode map folded by low nibble; columns share operand form
    always_comb begin
        form = FORM_1_1;
        if (lo[3]) begin
            case (hi)
                4'h7, 4'h8, 4'hA: form = FORM_2_2;
                4'hB: form = FORM_B33;
                4'hD: form = FORM_B22;
                default: form = FORM_1_1;
            endcase
        end else if (lo[3:1] == 3'b011) begin
            case (hi)
                4'h7, 4'h8, 4'hA: form = FORM_2_2;
                4'hB: form = FORM_B34;
                default: form = FORM_1_2;
            endcase
        end else begin
            case (lo)
                4'h0: begin
                    case (hi)
                        4'h0: form = FORM_1_1;
                        4'h1, 4'h2, 4'h3: form = FORM_B33;
                        4'h4, 4'h5, 4'h6, 4'h7: form = FORM_B22;
                        4'h8: form = FORM_2_3;
                        4'h9: form = FORM_3_3;
                        4'hE, 4'hF: form = FORM_1_3;
                        default: form = FORM_2_2;
                    endcase
                end
                4'h1: form = FORM_2_3;
                4'h2: begin
                    case (hi)
                        4'h0, 4'h1: form = FORM_3_4;
                        4'h2, 4'h3: form = FORM_1_5;
                        4'hE, 4'hF: form = FORM_1_3;
                        default: form = FORM_2_2;
                    endcase
                end
                4'h3: begin
                    case (hi)
                        4'h4, 4'h5, 4'h6: form = FORM_3_3;
                        4'h7, 4'h8, 4'h9, 4'hE, 4'hF: form = FORM_1_3;
                        default: form = FORM_1_1;
                    endcase
                end
                4'h4: begin
                    case (hi)
                        4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: form = FORM_1_1;
                        4'h8: form = FORM_1_8;
                        4'hA: form = FORM_1_4;
                        4'hB: form = FORM_B33;
                        default: form = FORM_2_2;
                    endcase
                end
                default: begin
                    case (hi)
                        4'h7, 4'h8: form = FORM_3_3;
                        4'hA: form = FORM_1_1;
                        4'hB, 4'hD: form = FORM_B33;
                        default: form = FORM_2_2;
                    endcase
                end
            endcase
        end
    end

    // Form to byte count and not-taken clock count
    always_comb begin
        d.len = `LEN_1;
        d.cyc_nt = `CYC_FIRST;
        d.branch = 1'b0;
        unique case (form)
            FORM_1_1: d.cyc_nt = `CYC_FIRST;
            FORM_1_2: d.cyc_nt = {2'b00, `LEN_2};
            FORM_1_3: d.cyc_nt = `CYC_XFER;
            FORM_1_4: d.cyc_nt = `CYC_MULTIPLY;
            FORM_1_5: d.cyc_nt = `CYC_RET;
            FORM_1_8: d.cyc_nt = `CYC_MAX;
            FORM_2_2: begin
                d.len = `LEN_2;
                d.cyc_nt = {2'b00, `LEN_2};
            end
            FORM_2_3: begin
                d.len = `LEN_2;
                d.cyc_nt = `CYC_XFER;
            end
            FORM_3_3: begin
                d.len = `LEN_3;
                d.cyc_nt = {2'b00, `LEN_3};
            end
            FORM_3_4: begin
                d.len = `LEN_3;
                d.cyc_nt = `CYC_MULTIPLY;
            end
            FORM_B22: begin
                d.len = `LEN_2;
                d.cyc_nt = {2'b00, `LEN_2};
                d.branch = 1'b1;
            end
            FORM_B33: begin
                d.len = `LEN_3;
                d.cyc_nt = {2'b00, `LEN_3};
                d.branch = 1'b1;
            end
            FORM_B34: begin
                d.len = `LEN_3;
                d.cyc_nt = `CYC_MULTIPLY;
                d.branch = 1'b1;
            end
        endcase
    end

    // Taken branch costs one clock more than not taken
    assign d.cyc_tk = `CYC_W'(d.cyc_nt + `BR_PENALTY);

    // External-data moves sit at columns 0, 2, 3 of rows E and F
    assign d.xdata = (hi[3:1] == 3'b111) && (lo == 4'h0 || lo == 4'h2 || lo == 4'h3);
    assign d.xdata_wr = d.xdata && hi[0];
    assign d.code_move = (lo == 4'h3) && (hi == 4'h8 || hi == 4'h9);
endmodule

// ==== insn_sequencer.sv ====
`timescale 1ns/1ns
`include "core_timing_map.svh"
module insn_sequencer (
    input wire logic mclk,
    input wire logic rst,
    output logic [`PC_W-1:0] code_addr,
    output logic code_rd,
    input wire logic [7:0] code_data,
    input wire logic branch_taken,
    input wire logic jump_load,
    input wire logic [`PC_W-1:0] jump_pc,
    input wire logic prog_store_en,
    output logic xfer_ram_req,
    output logic xfer_flash_req,
    output logic xfer_we,
    output logic insn_done,
    output logic [7:0] insn_opcode,
    output logic [`CYC_W-1:0] insn_cycles,
    input wire logic dbg_halt_req,
    input wire logic dbg_run_req,
    input wire logic dbg_step_req,
    input wire logic dbg_bp_wr,
    input wire logic [`BP_IDX_W-1:0] dbg_bp_idx,
    input wire logic [`PC_W-1:0] dbg_bp_addr,
    input wire logic dbg_bp_en,
    output logic halted,
    output logic bp_hit,
    output logic dbg_access_ok
);
    import core_timing_pkg::*;

    dec_if dec();

    state_t state;
    logic [`CYC_W-1:0] cnt;
    logic [7:0] opcode;
    logic taken_q;
    logic stepping;
    logic step_done;
    logic skip_bp;
    logic first;
    logic boundary;
    logic halt_now;
    logic running;
    logic end_now;
    logic bp_match;
    logic [`BP_NUM-1:0] bp_hits;

    // Shared opcode table keeps the timing source in one place
    opcode_timing_decode u_dec (
        .d(dec)
    );

    // Opcode comes straight off the fetch bus on the first clock
    assign first = (cnt == `CYC_FIRST);
    assign dec.opcode = first ? code_data : opcode;

    // Halting only at boundaries keeps instructions atomic
    assign boundary = (state == ST_RUN) && first;
    assign halt_now = boundary && (dbg_halt_req || (bp_match && !skip_bp) || step_done);
    assign running = (state == ST_RUN) && !halt_now;

    // Final clock: not-taken count, or one more once taken
    always_comb begin
        end_now = 1'b0;
        if (running) begin
            if (taken_q) begin
                end_now = (cnt == dec.cyc_tk);
            end else begin
                end_now = (cnt == dec.cyc_nt) && !(dec.branch && branch_taken);
            end
        end
    end

    // Fetch one byte per clock until the length is read
    assign code_rd = running && (cnt <= {2'b00, dec.len});

    // Cycle index counts raw system clocks, restarting each instruction
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt <= `CYC_FIRST;
        end else if (end_now) begin
            cnt <= `CYC_FIRST;
        end else if (running) begin
            cnt <= `CYC_W'(cnt + `CYC_FIRST);
        end
    end

    // Program counter advances only on fetch; jump wins at the end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            code_addr <= `PC_RESET;
        end else if (end_now && jump_load) begin
            code_addr <= jump_pc;
        end else if (code_rd) begin
            code_addr <= `PC_W'(code_addr + `PC_W'(1));
        end
    end

    // Opcode held for the operand and execute clocks
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            opcode <= `OPCODE_RESET;
        end else if (running && first) begin
            opcode <= code_data;
        end
    end

    // Taken outcome sampled in the not-taken final clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            taken_q <= 1'b0;
        end else if (end_now) begin
            taken_q <= 1'b0;
        end else if (running && dec.branch && cnt == dec.cyc_nt && branch_taken) begin
            taken_q <= 1'b1;
        end
    end

    // Completion report for the datapath and the debug host
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            insn_done <= 1'b0;
            insn_opcode <= `OPCODE_RESET;
            insn_cycles <= `CYC_FIRST;
        end else begin
            insn_done <= end_now;
            if (end_now) begin
                insn_opcode <= dec.opcode;
                insn_cycles <= cnt;
            end
        end
    end

    // Data moves go only to on-chip RAM or flash; no off-chip strobe exists
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            xfer_ram_req <= 1'b0;
            xfer_flash_req <= 1'b0;
            xfer_we <= 1'b0;
        end else begin
            xfer_ram_req <= running && first && dec.xdata && !prog_store_en;
            xfer_flash_req <= running && first
                && ((dec.xdata && prog_store_en) || dec.code_move);
            xfer_we <= running && first && dec.xdata_wr;
        end
    end

    // Breakpoint comparators in private flops, not application RAM
    generate
        for (genvar i = 0; i < `BP_NUM; i++) begin : g_bp
            logic [`PC_W-1:0] addr;
            logic en;
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    addr <= `PC_RESET;
                    en <= 1'b0;
                end else if (dbg_bp_wr && dbg_bp_idx == `BP_IDX_W'(i)) begin
                    addr <= dbg_bp_addr;
                    en <= dbg_bp_en;
                end
            end
            assign bp_hits[i] = en && (addr == code_addr);
        end
    endgenerate
    assign bp_match = |bp_hits;

    // Run control; run beats step when both arrive together
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= ST_RUN;
        end else begin
            unique case (state)
                ST_RUN: begin
                    if (halt_now) begin
                        state <= ST_HALT;
                    end
                end
                ST_HALT: begin
                    if (dbg_run_req || dbg_step_req) begin
                        state <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // Step runs one whole instruction; resume skips the breakpoint it sits on
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stepping <= 1'b0;
            step_done <= 1'b0;
            skip_bp <= 1'b0;
        end else if (state == ST_HALT) begin
            stepping <= dbg_step_req && !dbg_run_req;
            step_done <= 1'b0;
            skip_bp <= dbg_run_req || dbg_step_req;
        end else if (end_now) begin
            step_done <= stepping;
            skip_bp <= 1'b0;
        end
    end

    // Status seen by the debug link controller
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bp_hit <= 1'b0;
        end else begin
            bp_hit <= halt_now && bp_match && !skip_bp;
        end
    end
    assign halted = (state == ST_HALT);
    // Core is quiet while halted, so host memory reads cost nothing
    assign dbg_access_ok = halted;

    // Checks below use the opcode presented on the first clock
    logic start;
    logic alu_row;
    assign start = running && first;
    assign alu_row = code_data[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    alu_reg_clk_a: assert property (
        start && alu_row && code_data[3] |-> end_now && code_rd
    ) else $error("register ALU op not one clock");

    alu_dir_clk_a: assert property (
        start && alu_row && code_data[3:0] == 4'h5 |-> !end_now ##1 (end_now && code_rd)
    ) else $error("direct ALU op not two clocks");

    alu_ind_clk_a: assert property (
        start && alu_row && code_data[3:1] == 3'b011 |-> code_rd ##1 (!code_rd && end_now)
    ) else $error("indirect ALU op not one byte two clocks");

    alu_imm_clk_a: assert property (
        start && alu_row && code_data[3:0] == 4'h4 |-> code_rd ##1 (code_rd && end_now)
    ) else $error("immediate ALU op not two clocks");

    logic_dir_clk_a: assert property (
        start && code_data inside {8'h42, 8'h52, 8'h62} |-> !end_now ##1 end_now
    ) else $error("logic into direct not two clocks");

    logic_imm_clk_a: assert property (
        start && code_data inside {8'h43, 8'h53, 8'h63} |-> (!end_now && code_rd) [*2]
            ##1 (end_now && code_rd)
    ) else $error("immediate logic into direct not three clocks");

    branch_outcome_a: assert property (
        running && dec.branch && cnt == dec.cyc_nt && !taken_q
            |-> if (branch_taken) (!end_now ##1 end_now) else end_now
    ) else $error("branch outcome timing wrong");

    div_eight_clk_a: assert property (
        start && code_data == `OP_DIV |-> !end_now [*7] ##1 end_now
    ) else $error("divide not eight clocks");

    multiply_clk_a: assert property (
        start && code_data == `OP_MULTIPLY |-> !end_now [*3] ##1 end_now
    ) else $error("multiply not four clocks");

    // Reported length must stay inside the one-to-eight clock window
    cycles_bound_a: assert property (
        insn_done |-> (insn_cycles >= `CYC_FIRST) && (insn_cycles <= `CYC_MAX)
    ) else $error("reported clock count out of range");

    // Each fetched byte moves the PC on by one unless a jump lands
    fetch_advance_a: assert property (
        code_rd && !(end_now && jump_load) |=> code_addr == $past(code_addr) + 16'h0001
    ) else $error("fetch did not advance the PC by one");

    pc_hold_a: assert property (
        running && !code_rd && !end_now |=> $stable(code_addr) && !first
    ) else $error("PC moved during execute clocks");

    xfer_target_a: assert property (
        start && dec.xdata |=> (xfer_ram_req != xfer_flash_req)
    ) else $error("external-data move target not unique");

    halt_quiet_a: assert property (
        halted |-> !code_rd ##1 (!xfer_ram_req && !xfer_flash_req)
    ) else $error("core active while halted");

    bp_stop_a: assert property (
        boundary && bp_match && !skip_bp |-> !code_rd ##1 (halted && bp_hit)
    ) else $error("breakpoint did not halt");
endmodule

// ==== code_mem.sv ====
`timescale 1ns/1ns
`include "core_timing_map.svh"
module code_mem (
    input wire logic mclk,
    input wire logic [`PC_W-1:0] code_addr,
    input wire logic code_rd,
    output logic [7:0] code_data
);
    logic [7:0] mem [0:4095];
    logic [7:0] last;

    // Zero-wait read; when not fetched the bus shows the inverse, so stale bytes never pass
    always_comb begin
        code_data = code_rd ? mem[code_addr[11:0]] : ~last;
    end

    // Last byte handed out
    always_ff @(posedge mclk) begin
        if (code_rd) begin
            last <= mem[code_addr[11:0]];
        end
    end
endmodule

// ==== mcu_core_instruction_timing_test.sv ====
`timescale 1ns/1ns
`include "core_timing_map.svh"
module mcu_core_instruction_timing_test;
    logic mclk;
    logic rst;
    logic [`PC_W-1:0] code_addr;
    logic code_rd;
    logic [7:0] code_data;
    logic branch_taken;
    logic jump_load;
    logic [`PC_W-1:0] jump_pc;
    logic prog_store_en;
    logic xfer_ram_req;
    logic xfer_flash_req;
    logic xfer_we;
    logic insn_done;
    logic [7:0] insn_opcode;
    logic [`CYC_W-1:0] insn_cycles;
    logic dbg_halt_req;
    logic dbg_run_req;
    logic dbg_step_req;
    logic dbg_bp_wr;
    logic [`BP_IDX_W-1:0] dbg_bp_idx;
    logic [`PC_W-1:0] dbg_bp_addr;
    logic dbg_bp_en;
    logic halted;
    logic bp_hit;
    logic dbg_access_ok;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed;
    int p;
    int pend;
    int n;
    logic [15:0] bpa;
    logic [15:0] a0;
    logic [30:0] e;
    logic [30:0] exp_q[$]; // Next pc, opcode, clocks, ram/flash/write
    logic [2:0] xacc;
    logic [7:0] bases [6] = '{8'h20, 8'h30, 8'h90, 8'h50, 8'h40, 8'h60};

    insn_sequencer u_dut (
        .mclk, .rst, .code_addr, .code_rd, .code_data, .branch_taken, .jump_load,
        .jump_pc, .prog_store_en, .xfer_ram_req, .xfer_flash_req, .xfer_we,
        .insn_done, .insn_opcode, .insn_cycles, .dbg_halt_req, .dbg_run_req,
        .dbg_step_req, .dbg_bp_wr, .dbg_bp_idx, .dbg_bp_addr, .dbg_bp_en,
        .halted, .bp_hit, .dbg_access_ok
    );

    code_mem u_mem (.mclk, .code_addr, .code_rd, .code_data);

    initial begin
        mclk = 1'b0;
        forever begin
            #2 mclk = ~mclk;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_compared++;
        if (seen !== expv) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task automatic stop_test();
        $display("compared=%0d mismatches=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred clocks the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end

    // Score each finished instruction; an empty queue means idle filler
    always @(negedge mclk) begin
        if (rst) begin
            xacc = 3'h0;
        end else begin
            xacc = xacc | {xfer_ram_req, xfer_flash_req, xfer_we};
            if (insn_done === 1'b1) begin
                if (exp_q.size() > 0) begin
                    e = exp_q.pop_front();
                    check({insn_opcode, insn_cycles, xacc}, e[14:0]);
                    check(code_addr, e[30:15]);
                end else begin
                    check({insn_opcode, insn_cycles, xacc}, {8'h00, 4'h1, 3'h0});
                end
                xacc = 3'h0;
            end
        end
    end

    // Random mix of forms; the first thirteen take each of the thirteen cases once
    task automatic build(input logic pse, input logic tk, output int a);
        int k;
        int j;
        int f;
        int bi;
        int len;
        int c;
        logic [31:0] r;
        logic [7:0] op;
        logic [7:0] b;
        logic [2:0] xf;
        a = 0;
        for (k = 0; k < 4096; k++) begin
            u_mem.mem[k] = 8'h00;
        end
        exp_q.delete();
        for (k = 0; k < 70; k++) begin
            r = $random(seed);
            f = (k < 13) ? k : r[31:24] % 13;
            bi = (f == 4 || f == 5) ? 3 + r[9:8] % 3 : r[10:8] % 6;
            b = bases[bi];
            xf = 3'h0;
            case (f)
                0: begin op = b + 8'h08 + r[2:0]; len = 1; c = 1; end
                1: begin op = b + 8'h05; len = 2; c = 2; end
                2: begin op = b + 8'h06 + r[0]; len = 1; c = 2; end
                3: begin op = b + 8'h04; len = 2; c = 2; end
                4: begin op = b + 8'h02; len = 2; c = 2; end
                5: begin op = b + 8'h03; len = 3; c = 3; end
                6: begin op = 8'hA4; len = 1; c = 4; end
                7: begin op = 8'h84; len = 1; c = 8; end
                8: begin op = 8'hF0; len = 1; c = 3; xf = {~pse, pse, 1'b1}; end
                9: begin op = 8'hE0; len = 1; c = 3; xf = {~pse, pse, 1'b0}; end
                10: begin op = 8'h93; len = 1; c = 3; xf = 3'h2; end
                11: begin op = 8'h60; len = 2; c = 2 + tk; end
                default: begin op = 8'h00; len = 1; c = 1; end
            endcase
            u_mem.mem[a] = op;
            for (j = 1; j < len; j++) begin
                u_mem.mem[a + j] = r[23:16] + 8'(j);
            end
            a = a + len;
            exp_q.push_back({16'(a), op, 4'(c), xf});
        end
    endtask

    task automatic wait_halt(input logic v);
        int t;
        for (t = 0; t < 100 && halted !== v; t++) begin
            @(negedge mclk);
        end
    endtask

    task automatic pulse_run();
        dbg_run_req = 1'b1;
        @(negedge mclk);
        dbg_run_req = 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        seed = 32'hA20F31E9;
        {branch_taken, jump_load, prog_store_en, dbg_halt_req, dbg_run_req} = '0;
        {dbg_step_req, dbg_bp_wr, dbg_bp_en} = '0;
        jump_pc = '0;
        dbg_bp_idx = '0;
        dbg_bp_addr = '0;
        for (p = 0; p < 2; p++) begin
            // Pass 0: branches fall through, external-data moves hit RAM; pass 1 the opposite
            rst = 1'b1;
            build(p[0], p[0], pend);
            prog_store_en = p[0];
            branch_taken = p[0];
            repeat (16) @(negedge mclk);
            rst = 1'b0;
            while (exp_q.size() > 0) begin
                @(negedge mclk);
            end
            // Breakpoint ahead in the idle stretch
            bpa = 16'(pend + 20);
            u_mem.mem[bpa] = 8'hA4;
            dbg_bp_idx = 2'($random(seed));
            // Disabled entry nearer in the stream must not stop the core
            dbg_bp_addr = bpa - 16'h000A;
            dbg_bp_en = 1'b0;
            dbg_bp_wr = 1'b1;
            @(negedge mclk);
            dbg_bp_idx = dbg_bp_idx + 2'h1;
            dbg_bp_addr = bpa;
            dbg_bp_en = 1'b1;
            @(negedge mclk);
            dbg_bp_wr = 1'b0;
            wait_halt(1'b1);
            check({halted, bp_hit, dbg_access_ok, code_rd, code_addr}, {4'hE, bpa});
            repeat (5) @(negedge mclk);
            check({halted, bp_hit, dbg_access_ok, code_rd, code_addr}, {4'hA, bpa});
            // Single step over the multiply, with a jump landing at its final clock
            jump_pc = bpa + 16'h0064;
            jump_load = 1'b1;
            exp_q.push_back({jump_pc, 8'hA4, 4'h4, 3'h0});
            dbg_step_req = 1'b1;
            @(negedge mclk);
            dbg_step_req = 1'b0;
            wait_halt(1'b0);
            wait_halt(1'b1);
            check({halted, bp_hit, code_addr}, {2'h2, jump_pc});
            check(exp_q.size(), 0);
            jump_load = 1'b0;
            // Free run: one finished instruction every clock
            pulse_run();
            repeat (3) @(negedge mclk);
            n = 0;
            repeat (8) begin
                @(negedge mclk);
                n = n + (insn_done === 1'b1);
            end
            check(n, 8);
            // Host stop request; the core must freeze with no fetch
            dbg_halt_req = 1'b1;
            wait_halt(1'b1);
            a0 = code_addr;
            repeat (4) @(negedge mclk);
            check({halted, bp_hit, code_rd, insn_done, code_addr}, {4'h8, a0});
            dbg_halt_req = 1'b0;
            // Run and step together: run wins, so no halt after one NOP
            dbg_step_req = 1'b1;
            pulse_run();
            dbg_step_req = 1'b0;
            @(negedge mclk);
            check({halted, dbg_access_ok}, 2'h0);
            @(negedge mclk);
            check(halted, 1'b0);
        end
        stop_test();
    end
endmodule
